// ==== logic/sea_params.svh ====
// constants for the saturating event accumulator
`ifndef SEA_PARAMS_SVH
`define SEA_PARAMS_SVH

`define SEA_CLK_PERIOD_NS     50
`define SEA_DEBOUNCE_US       500
`define SEA_DEBOUNCE_CYC      ((`SEA_DEBOUNCE_US * 1000) / `SEA_CLK_PERIOD_NS)
`define SEA_DEBOUNCE_W        17
`define SEA_DIGITS            7
`define SEA_RATE_W            24
`define SEA_GATE_MS           1
`define SEA_GATE_CYC          ((`SEA_GATE_MS * 1000000) / `SEA_CLK_PERIOD_NS)
`define SEA_GATE_W            25
`define SEA_CHAR_PROMPT       8'h2A
`define SEA_CHAR_CR           8'h0D
`define SEA_CHAR_ZERO         8'h30

`endif

// ==== logic/sea_pkg.sv ====
// types for the saturating event accumulator
package sea_pkg;
    typedef logic [3:0] sea_digit_t;
    typedef logic [27:0] sea_bcd_t;
    typedef enum logic [1:0] {
        SEA_CMD_NONE,
        SEA_CMD_READ,
        SEA_CMD_CLEAR,
        SEA_CMD_READ_CLEAR
    } sea_cmd_e;
    typedef enum {
        SEA_TX_IDLE,
        SEA_TX_PROMPT,
        SEA_TX_DIGIT,
        SEA_TX_CR
    } sea_tx_state_e;
endpackage

// ==== logic/sea_bcd_digit.sv ====
// one decimal digit of the event total with carry chain
`timescale 1ns/100ps
`include "sea_params.svh"

module sea_bcd_digit (
    input  wire logic              i_core_clk,
    input  wire logic              i_reset,
    input  wire logic              i_clear,
    input  wire logic              i_inc,
    output logic [3:0]             o_digit,
    output logic                   o_carry
);
    logic [3:0] digit_q;
    logic [3:0] digit_d;
    logic       is_nine;

    assign is_nine = (digit_q == 4'h9);
    // clear with a carry-in restarts at one, and nothing ripples upward
    assign o_carry = i_inc & is_nine & ~i_clear;
    assign o_digit = digit_q;
    assign digit_d = i_clear ? {3'h0, i_inc} : (i_inc ? (is_nine ? 4'h0 : 4'(digit_q + 4'h1)) : digit_q);

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            digit_q <= 4'h0;
        end else begin
            digit_q <= digit_d;
        end
    end
endmodule

// ==== logic/sea_accumulator.sv ====
// saturating decimal event accumulator with debounce, rate and ascii replies
`timescale 1ns/100ps
`include "sea_params.svh"

// Overview of operation
// RL1 - count events from first digital input
// RL2 - debounce switch input before counting
// RL3 - total is seven decimal digits, max 9999999
// RL4 - saturate at maximum, hold until cleared
// RL5 - read returns total without changing it
// RL6 - clear and read-clear zero the total
// RL7 - read-clear reports total then clears
// RL8 - read-clear atomic, no event lost
// RL9 - total cleared at power-up reset
// RL10 - restart and line break keep total
// RL11 - rate read independent of total
// RL12 - every response ends with carriage return
// RL13 - every response starts with asterisk
// RL14 - total sent as seven ascii digits
module sea_accumulator (
    input  wire logic              i_core_clk,
    input  wire logic              i_reset,
    input  wire logic              i_event_count_input,
    input  wire logic              i_cmd_valid,
    input  sea_pkg::sea_cmd_e      i_cmd,
    input  wire logic              i_remote_restart_cmd,
    input  wire logic              i_line_break,
    input  wire logic              i_tx_ready,
    output logic                   o_cmd_ready,
    output logic                   o_tx_valid,
    output logic [7:0]             o_tx_char,
    output logic [`SEA_RATE_W-1:0] o_rate,
    output logic [27:0]            o_total
);
    // ----------------------------------------------------------------
    // debounce
    // ----------------------------------------------------------------
    logic                      in_q;
    logic                      stable_q;
    logic                      stable_d;
    logic [`SEA_DEBOUNCE_W-1:0] db_cnt_q;
    logic [`SEA_DEBOUNCE_W-1:0] db_cnt_d;
    logic                      db_done;
    logic                      event_pulse;

    assign db_done     = (db_cnt_q == `SEA_DEBOUNCE_W'(`SEA_DEBOUNCE_CYC - 1));
    assign stable_d    = (in_q != stable_q && db_done) ? in_q : stable_q;          // [RL2]
    assign db_cnt_d    = (in_q == stable_q || db_done) ? '0 : `SEA_DEBOUNCE_W'(db_cnt_q + 1'b1);
    assign event_pulse = in_q & ~stable_q & db_done;                               // [RL1]

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            in_q     <= 1'b0;
            stable_q <= 1'b0;
            db_cnt_q <= '0;
        end else begin
            in_q     <= i_event_count_input;
            stable_q <= stable_d;
            db_cnt_q <= db_cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // decimal total
    // ----------------------------------------------------------------
    logic [6:0] carry;
    logic [7:0] inc_chain;
    logic [27:0] total;
    logic       at_max;
    logic       take;
    logic       clr;
    logic       rd_clr;

    assign take   = i_cmd_valid & o_cmd_ready;
    assign rd_clr = take & (i_cmd == sea_pkg::SEA_CMD_READ_CLEAR);
    assign clr    = (take & (i_cmd == sea_pkg::SEA_CMD_CLEAR)) | rd_clr;            // [RL6]
    assign at_max = (total == 28'h9999999);                                        // [RL3]
    // event on a read-clear edge goes into the new count; a plain clear drops it
    assign inc_chain[0] = event_pulse & (clr ? rd_clr : ~at_max);                  // [RL4] [RL8]

    genvar g;
    generate
        for (g = 0; g < `SEA_DIGITS; g++) begin : g_dig
            sea_bcd_digit u_dig (
                .i_core_clk (i_core_clk),
                .i_reset    (i_reset),                                             // [RL9]
                .i_clear    (clr),
                .i_inc      (inc_chain[g]),
                .o_digit    (total[4*g +: 4]),
                .o_carry    (carry[g])
            );
            assign inc_chain[g+1] = carry[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // rate: events per gate period, separate from total
    // ----------------------------------------------------------------
    logic [`SEA_GATE_W-1:0] gate_q;
    logic [`SEA_RATE_W-1:0] rate_cnt_q;
    logic [`SEA_RATE_W-1:0] rate_q;
    logic                   gate_end;

    assign gate_end = (gate_q == `SEA_GATE_W'(`SEA_GATE_CYC - 1));

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            gate_q     <= '0;
            rate_cnt_q <= '0;
            rate_q     <= '0;
        end else begin
            gate_q     <= gate_end ? '0 : `SEA_GATE_W'(gate_q + 1'b1);
            rate_cnt_q <= gate_end ? `SEA_RATE_W'(event_pulse)
                                   : `SEA_RATE_W'(rate_cnt_q + `SEA_RATE_W'(event_pulse)); // [RL11]
            if (gate_end) begin
                rate_q <= rate_cnt_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // reply sequencer
    // ----------------------------------------------------------------
    sea_pkg::sea_tx_state_e state_q;
    sea_pkg::sea_tx_state_e state_d;
    logic [27:0] snap_q;
    logic [2:0]  idx_q;
    logic [2:0]  idx_d;
    logic        with_digits_q;
    logic        tx_valid_d;
    logic [7:0]  tx_char_d;
    logic        step;

    assign step      = o_tx_valid & i_tx_ready;

    always_comb begin
        state_d    = state_q;
        idx_d      = idx_q;
        tx_valid_d = o_tx_valid;
        tx_char_d  = o_tx_char;
        unique case (state_q)
            sea_pkg::SEA_TX_IDLE: begin
                if (take && i_cmd != sea_pkg::SEA_CMD_NONE) begin
                    state_d    = sea_pkg::SEA_TX_PROMPT;
                    tx_valid_d = 1'b1;
                    tx_char_d  = `SEA_CHAR_PROMPT;                                 // [RL13]
                end
            end
            sea_pkg::SEA_TX_PROMPT: begin
                if (step) begin
                    idx_d = 3'h0;
                    if (with_digits_q) begin
                        state_d   = sea_pkg::SEA_TX_DIGIT;
                        tx_char_d = `SEA_CHAR_ZERO | {4'h0, snap_q[27:24]};        // [RL14]
                    end else begin
                        state_d   = sea_pkg::SEA_TX_CR;
                        tx_char_d = `SEA_CHAR_CR;
                    end
                end
            end
            sea_pkg::SEA_TX_DIGIT: begin
                if (step) begin
                    if (idx_q == 3'h6) begin
                        state_d   = sea_pkg::SEA_TX_CR;
                        tx_char_d = `SEA_CHAR_CR;                                  // [RL12]
                    end else begin
                        idx_d     = 3'(idx_q + 3'h1);
                        tx_char_d = `SEA_CHAR_ZERO | {4'h0, snap_q[4*(5 - idx_q) +: 4]};
                    end
                end
            end
            sea_pkg::SEA_TX_CR: begin
                if (step) begin
                    state_d    = sea_pkg::SEA_TX_IDLE;
                    tx_valid_d = 1'b0;
                    tx_char_d  = 8'h00;
                end
            end
        endcase
    end

    // restart and line break deliberately do not touch the total  [RL10]
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_q       <= sea_pkg::SEA_TX_IDLE;
            snap_q        <= '0;
            idx_q         <= 3'h0;
            with_digits_q <= 1'b0;
            o_tx_valid    <= 1'b0;
            o_tx_char     <= 8'h00;
            o_cmd_ready   <= 1'b1;
            o_rate        <= '0;
            o_total       <= '0;
        end else begin
            state_q    <= state_d;
            idx_q      <= idx_d;
            o_tx_valid <= tx_valid_d;
            o_tx_char  <= tx_char_d;
            o_cmd_ready <= (state_d == sea_pkg::SEA_TX_IDLE) & ~(take & i_cmd != sea_pkg::SEA_CMD_NONE);
            o_rate     <= rate_q;
            o_total    <= total;
            if (take && i_cmd != sea_pkg::SEA_CMD_NONE) begin
                snap_q        <= total;                                            // [RL5] [RL7]
                with_digits_q <= (i_cmd != sea_pkg::SEA_CMD_CLEAR);
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_prompt_sent;
        o_tx_valid && o_tx_char == `SEA_CHAR_PROMPT;
    endsequence

    a_clear_zeroes_total: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL6]
        clr |=> total == {27'h0, $past(rd_clr && event_pulse)}) else $error("total not zero after clear");
    a_saturate_holds: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL4]
        at_max && !clr |=> at_max) else $error("total left maximum");
    a_no_event_lost: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL8]
        event_pulse && !clr && !at_max && total[3:0] != 4'h9 |=> total[3:0] == $past(total[3:0]) + 4'h1)
        else $error("event not counted");
    a_read_keeps_total: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL5]
        take && i_cmd == sea_pkg::SEA_CMD_READ && !event_pulse |=> total == $past(total))
        else $error("read changed total");
    a_reply_prompt_first: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL13]
        take && i_cmd != sea_pkg::SEA_CMD_NONE |=> s_prompt_sent) else $error("reply lacks prompt");
    a_read_clear_snap: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL7]
        rd_clr |=> snap_q == $past(total) && total == {27'h0, $past(event_pulse)})
        else $error("read-clear not atomic");
    a_read_clear_keeps: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL8]
        rd_clr && event_pulse |=> total == 28'h1) else $error("event lost on read-clear");
    a_no_top_carry: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL4]
        !inc_chain[7]) else $error("total wrapped past maximum");
    a_restart_keeps: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL10]
        (i_remote_restart_cmd || i_line_break) && !clr && !event_pulse |=> total == $past(total))
        else $error("restart changed total");
    a_reply_ends_cr: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL12]
        state_q == sea_pkg::SEA_TX_CR |-> o_tx_valid && o_tx_char == `SEA_CHAR_CR)
        else $error("reply end not cr");
    a_digit_ascii: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL14]
        state_q == sea_pkg::SEA_TX_DIGIT |-> o_tx_char[7:4] == 4'h3 && o_tx_char[3:0] <= 4'h9)
        else $error("digit not ascii");
    a_event_needs_input: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RL1]
        event_pulse |-> in_q && $past(in_q, 1)) else $error("event without input");
endmodule

// ==== dv/sea_host_model.sv ====
// host model: issues commands and gathers reply characters
`timescale 1ns/100ps
`include "sea_params.svh"

module sea_host_model (
    input  wire logic         i_core_clk,
    input  wire logic         i_cmd_ready,
    input  wire logic         i_tx_valid,
    input  wire logic [7:0]   i_tx_char,
    output logic              o_cmd_valid,
    output sea_pkg::sea_cmd_e o_cmd,
    output logic              o_tx_ready
);
    int seed_h = 1;

    initial begin
        o_cmd_valid = 1'b0;
        o_cmd       = sea_pkg::SEA_CMD_NONE;
        o_tx_ready  = 1'b1;
    end

    // one command; reply shifted into rep, ok low when it hangs
    task automatic issue(input sea_pkg::sea_cmd_e c, input bit slow, output logic [71:0] rep,
                         output int n, output bit ok);
        int         k;
        bit         hit;
        logic [7:0] ch;
        rep = '0;
        n = 0;
        ok = 1'b0;
        @(negedge i_core_clk);
        o_cmd_valid = 1'b1;
        o_cmd = c;
        // ready looked at mid-cycle, where it has settled
        for (k = 0; k < 20 && !ok; k++) begin
            ok = (i_cmd_ready === 1'b1);
            @(posedge i_core_clk);
            if (!ok) begin
                @(negedge i_core_clk);
            end
        end
        @(negedge i_core_clk);
        o_cmd_valid = 1'b0;
        o_cmd = sea_pkg::sea_cmd_e'($random(seed_h) & 3);
        ok = 1'b0;
        for (k = 0; k < 400 && !ok; k++) begin
            o_tx_ready = slow ? 1'($random(seed_h)) : 1'b1;
            hit = (i_tx_valid === 1'b1) && o_tx_ready;
            ch = i_tx_char;
            @(posedge i_core_clk);
            if (hit) begin
                rep = {rep[63:0], ch};
                n++;
                ok = (ch === `SEA_CHAR_CR);
            end
            @(negedge i_core_clk);
        end
        o_tx_ready = 1'b1;
    endtask
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the saturating event accumulator
`timescale 1ns/100ps
`include "sea_params.svh"
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module tb_top;
    logic                   i_core_clk;
    logic                   i_reset;
    logic                   i_event_count_input;
    logic                   i_cmd_valid;
    sea_pkg::sea_cmd_e      i_cmd;
    logic                   i_remote_restart_cmd;
    logic                   i_line_break;
    logic                   i_tx_ready;
    logic                   o_cmd_ready;
    logic                   o_tx_valid;
    logic [7:0]             o_tx_char;
    logic [`SEA_RATE_W-1:0] o_rate;
    logic [27:0]            o_total;
    logic [71:0]            rep;
    int                     n;
    bit                     ok;
    int                     r1;
    int                     n_errors = 0;
    int                     comparisons = 0;
    int                     seed = 1;
    int                     cyc = 0;

    sea_accumulator sea_accumulator_inst (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_event_count_input(i_event_count_input), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
        .i_remote_restart_cmd(i_remote_restart_cmd), .i_line_break(i_line_break),
        .i_tx_ready(i_tx_ready), .o_cmd_ready(o_cmd_ready), .o_tx_valid(o_tx_valid),
        .o_tx_char(o_tx_char), .o_rate(o_rate), .o_total(o_total));

    sea_host_model sea_host_model_inst (.i_core_clk(i_core_clk), .i_cmd_ready(o_cmd_ready),
        .i_tx_valid(o_tx_valid), .i_tx_char(o_tx_char), .o_cmd_valid(i_cmd_valid),
        .o_cmd(i_cmd), .o_tx_ready(i_tx_ready));

    function automatic sea_pkg::sea_bcd_t to_bcd(input int v);
        sea_pkg::sea_bcd_t b;
        b = '0;
        for (int i = 0; i < `SEA_DIGITS; i++) begin
            b[4*i +: 4] = 4'(v % 10);
            v = v / 10;
        end
        return b;
    endfunction

    function automatic logic [71:0] exp_read(input int v);
        sea_pkg::sea_bcd_t b;
        logic [71:0]       r;
        b = to_bcd(v);
        r = {`SEA_CHAR_PROMPT, 56'h0, `SEA_CHAR_CR};
        for (int i = 0; i < `SEA_DIGITS; i++) begin
            r[8+8*i +: 8] = `SEA_CHAR_ZERO + {4'h0, b[4*i +: 4]};
        end
        return r;
    endfunction

    function automatic int dec(input logic [71:0] r);
        int v;
        v = 0;
        for (int i = `SEA_DIGITS - 1; i >= 0; i--) begin
            v = v * 10 + int'(r[8+8*i +: 8] - `SEA_CHAR_ZERO);
        end
        return v;
    endfunction

    task automatic complete_run();
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic run_cmd(input sea_pkg::sea_cmd_e c, input bit slow);
        sea_host_model_inst.issue(c, slow, rep, n, ok);
        if (!ok) begin
            n_errors++;
            complete_run();
        end
    endtask

    task automatic check_read(input int v, input bit slow);
        run_cmd(sea_pkg::SEA_CMD_READ, slow);
        `CHK(n, 9)
        `CHK(rep, exp_read(v))
        `CHK(o_total, to_bcd(v))
    endtask

    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end

    // posedges since reset release, for gate timing
    always @(posedge i_core_clk) begin
        cyc <= i_reset ? 0 : cyc + 1;
    end

    initial begin
        i_reset = 1'b1;
        i_event_count_input = 1'b0;
        i_remote_restart_cmd = 1'b0;
        i_line_break = 1'b0;
        repeat (20) @(negedge i_core_clk);
        i_reset = 1'b0;
        `CHK(o_total, 28'h0)
        `CHK(o_cmd_ready, 1'b1)
        check_read(0, 1'b0);
        // bounce: short pulses, then one held level
        for (int i = 0; i < 10; i++) begin
            i_event_count_input = ~i_event_count_input;
            repeat (1 + ($random(seed) & 31)) @(negedge i_core_clk);
        end
        i_event_count_input = 1'b1;
        repeat (`SEA_DEBOUNCE_CYC - 1) @(negedge i_core_clk);
        // read-clear taken on the very edge at which the event counts
        run_cmd(sea_pkg::SEA_CMD_READ_CLEAR, 1'b1);
        r1 = dec(rep);
        `CHK(rep, exp_read(r1))
        check_read(1 - r1, 1'b1);
        i_event_count_input = 1'b0;
        for (int i = 0; i < 8; i++) begin
            i_remote_restart_cmd = 1'($random(seed));
            i_line_break = 1'($random(seed));
            @(negedge i_core_clk);
        end
        i_remote_restart_cmd = 1'b0;
        i_line_break = 1'b0;
        check_read(1 - r1, 1'b0);
        run_cmd(sea_pkg::SEA_CMD_CLEAR, 1'b1);
        `CHK(n, 2)
        `CHK(rep[15:0], {`SEA_CHAR_PROMPT, `SEA_CHAR_CR})
        `CHK(o_total, 28'h0)
        `CHK(o_rate, 24'h0)
        check_read(0, 1'b1);
        run_cmd(sea_pkg::SEA_CMD_READ_CLEAR, 1'b0);
        `CHK(rep, exp_read(0))
        // first gate holds the one event, the second gate none
        repeat (`SEA_GATE_CYC + 5 - cyc) @(negedge i_core_clk);
        `CHK(o_rate, 24'h1)
        `CHK(o_total, 28'h0)
        repeat (2 * `SEA_GATE_CYC + 5 - cyc) @(negedge i_core_clk);
        `CHK(o_rate, 24'h0)
        complete_run();
    end
endmodule
